// ---- bench/ctrl_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module ctrl_model
(
   // Clock
   input  wire logic                 mclk_i,
   // Pins towards the device
   output var sdram_pins_pkg::pin_t  pins_o
);
   import sdram_pins_pkg::*;

   initial
   begin
      pins_o    = '1;
      pins_o.dq = 16'h5a5a;
   end

   // Code is {cs, ras, cas, we}; held for one edge, then deselected
   task automatic issue(input logic [3:0] code, input logic [1:0] bank,
                        input logic [12:0] addr, input logic [1:0] mask,
                        input logic [15:0] dq);
      @(posedge mclk_i);
      #1;
      {pins_o.cs_n, pins_o.ras_n, pins_o.cas_n, pins_o.we_n} = code;
      pins_o.bank = bank;
      pins_o.addr = addr;
      pins_o.mask = mask;
      pins_o.dq   = dq;
      @(posedge mclk_i);
      #1;
      pins_o.cs_n = 1'b1;
      // Inverted leftovers, so stale fields cannot pass by chance
      pins_o.bank = ~bank;
      pins_o.addr = ~addr;
      pins_o.dq   = ~dq;
   endtask : issue

   task automatic set_mask(input logic [1:0] mask);
      @(posedge mclk_i);
      #1;
      pins_o.mask = mask;
   endtask : set_mask
endmodule : ctrl_model
`default_nettype wire

// ---- bench/sdram_command_pin_decoder_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module sdram_command_pin_decoder_bench;
   import sdram_pins_pkg::*;

   logic        mclk_i     = 1'b0;
   logic        nrst_i     = 1'b0;
   logic        rd_valid_i = 1'b0;
   logic [15:0] rd_data_i  = 16'h0000;
   logic        wr_ready_i = 1'b0;
   pin_t        pins;
   logic [15:0] data_lines_o;
   logic [1:0]  data_lines_oe_o;
   cmd_t        cmd_o;
   logic [1:0]  bank_o;
   logic [12:0] row_o;
   logic [8:0]  col_o;
   logic        autoclose_o;
   logic [12:0] mode_o;
   logic [3:0]  bank_active_o;
   logic        wr_valid_o;
   wr_word_t    wr_word_o;
   wr_word_t    last_pop;
   logic        buf_ready_o;
   logic        wr_drop_o;
   int          n_fail     = 0;
   int          n_checks   = 0;
   int          n_drop     = 0;
   int          n_pop      = 0;
   int          cycles     = 0;

   ctrl_model u_ctrl (.mclk_i(mclk_i), .pins_o(pins));

   sdram_command_pin_decoder u_dut (
      .mclk_i(mclk_i), .nrst_i(nrst_i), .chip_select_n_i(pins.cs_n),
      .row_strobe_n_i(pins.ras_n), .col_strobe_n_i(pins.cas_n),
      .write_enable_n_i(pins.we_n), .bank_select_0_i(pins.bank[0]),
      .bank_select_1_i(pins.bank[1]), .addr_i(pins.addr),
      .low_byte_mask_i(pins.mask[0]), .high_byte_mask_i(pins.mask[1]),
      .data_lines_i(pins.dq), .data_lines_o(data_lines_o),
      .data_lines_oe_o(data_lines_oe_o), .cmd_o(cmd_o), .bank_o(bank_o),
      .row_o(row_o), .col_o(col_o), .autoclose_o(autoclose_o), .mode_o(mode_o),
      .bank_active_o(bank_active_o), .rd_valid_i(rd_valid_i), .rd_data_i(rd_data_i),
      .wr_valid_o(wr_valid_o), .wr_ready_i(wr_ready_i), .wr_word_o(wr_word_o),
      .buf_ready_o(buf_ready_o), .wr_drop_o(wr_drop_o));

   initial
   begin
      forever #2 mclk_i = ~mclk_i;
   end

   // Drain handshakes and drop pulses are counted at the edge that takes them
   always @(posedge mclk_i)
   begin
      cycles++;
      if (wr_drop_o === 1'b1)
         n_drop++;
      if (wr_valid_o === 1'b1 && wr_ready_i === 1'b1)
      begin
         n_pop++;
         last_pop = wr_word_o;
      end
      if (cycles == 2000)
      begin
         n_fail++;
         finish_test();
      end
   end

   task automatic finish_test();
      if (n_fail == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : finish_test

   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", name, exp, got);
      end
   endtask : check

   // Decoded pulse stands after the second edge past the pin sample edge
   task automatic cmd(input logic [3:0] code, input logic [1:0] bank, input logic [12:0] addr,
                      input logic [1:0] mask, input logic [15:0] dq);
      u_ctrl.issue(code, bank, addr, mask, dq);
      repeat (2) @(posedge mclk_i);
      #1;
   endtask : cmd

   task automatic t_banks();
      for (int b = 0; b < 4; b++)
      begin
         cmd(4'b0011, 2'(b), 13'h1abc ^ 13'(b), 2'b00, 16'h0000);
         check("cmd", CMD_OPEN, cmd_o);
         check("row", 13'h1abc ^ 13'(b), row_o);
         check("bank", b, bank_o);
         check("active", (32'h1 << (b + 1)) - 1, bank_active_o);
      end
      cmd(4'b0010, 2'd2, 13'h1bff, 2'b00, 16'h0000);
      check("cmd", CMD_CLOSE, cmd_o);
      check("active", 4'b1011, bank_active_o);
      cmd(4'b0101, 2'd1, 13'h15a5, 2'b00, 16'h0000);
      check("cmd", CMD_READ, cmd_o);
      check("col", 9'h1a5, col_o);
      check("autoclose", 1'b1, autoclose_o);
      check("active", 4'b1001, bank_active_o);
      cmd(4'b0010, 2'd1, 13'h0400, 2'b00, 16'h0000);
      check("cmd", CMD_CLOSE_ALL, cmd_o);
      check("active", 4'h0, bank_active_o);
   endtask : t_banks

   task automatic t_refuse();
      logic [3:0] codes [6] = '{4'b1011, 4'b1000, 4'b1010, 4'b0111, 4'b0110, 4'b0001};
      cmd(4'b0000, 2'd3, 13'h1e37, 2'b00, 16'h0000);
      check("cmd", CMD_MODE, cmd_o);
      check("mode", 13'h1e37, mode_o);
      cmd(4'b0011, 2'd3, 13'h0001, 2'b00, 16'h0000);
      foreach (codes[i])
      begin
         cmd(codes[i], 2'd0, 13'h0400, 2'b00, 16'h0000);
         check("cmd", CMD_NONE, cmd_o);
         check("active", 4'b1000, bank_active_o);
         check("mode", 13'h1e37, mode_o);
      end
   endtask : t_refuse

   task automatic t_write();
      cmd(4'b0100, 2'd3, 13'h0012, 2'b01, 16'hbeef);
      check("cmd", CMD_WRITE, cmd_o);
      check("col", 9'h012, col_o);
      check("autoclose", 1'b0, autoclose_o);
      check("active", 4'b1000, bank_active_o);
      @(posedge mclk_i);
      #1;
      check("wr_valid", 1'b1, wr_valid_o);
      check("wr_word", {16'hbe00, 2'b10}, wr_word_o);
      // Far side stalls while the buffer fills past its depth
      for (int i = 1; i < 17; i++)
         u_ctrl.issue(4'b0100, 2'd3, 13'h0000, 2'b00, 16'h1000 + 16'(i));
      repeat (8) @(posedge mclk_i);
      #1;
      check("buf_ready", 1'b0, buf_ready_o);
      check("drops", 1, n_drop);
      wr_ready_i = 1'b1;
      repeat (24) @(posedge mclk_i);
      #1;
      check("pops", 16, n_pop);
      check("last", {16'h100f, 2'b11}, last_pop);
      check("wr_valid", 1'b0, wr_valid_o);
      check("buf_ready", 1'b1, buf_ready_o);
   endtask : t_write

   task automatic t_read();
      rd_valid_i = 1'b1;
      rd_data_i  = 16'h3c5a;
      u_ctrl.set_mask(2'b01);
      repeat (6) @(posedge mclk_i);
      #1;
      check("dq", 16'h3c5a, data_lines_o);
      check("oe", 2'b10, data_lines_oe_o);
      u_ctrl.set_mask(2'b10);
      repeat (3) @(posedge mclk_i);
      #1;
      check("oe", 2'b10, data_lines_oe_o);
      @(posedge mclk_i);
      #1;
      check("oe", 2'b01, data_lines_oe_o);
      rd_valid_i = 1'b0;
      repeat (2) @(posedge mclk_i);
      #1;
      check("oe", 2'b00, data_lines_oe_o);
   endtask : t_read

   initial
   begin
      repeat (12) @(posedge mclk_i);
      #1;
      nrst_i = 1'b1;
      t_banks();
      t_refuse();
      t_write();
      t_read();
      finish_test();
   end
endmodule : sdram_command_pin_decoder_bench
`default_nettype wire

// ---- design/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int           W       = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         nrst_i,
   // Pins in, synchronised out
   input  wire logic [W-1:0] async_i,
   output logic      [W-1:0] sync_o
);

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sync_state_t;

   sync_state_t s_q;
   sync_state_t s_d;

   // First stage is read only by the second
   always_comb
   begin
      s_d.meta   = async_i;
      s_d.stable = s_q.meta;
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         s_q <= '{meta: RST_VAL, stable: RST_VAL};
      else
         s_q <= s_d;
   end

   assign sync_o = s_q.stable;

endmodule : pin_sync
`default_nettype wire

// ---- design/sdram_command_pin_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// [RL1] Open-row captures all thirteen address lines as row for selected bank.
// [RL2] Read and write take column from lines 0-8; line 10 requests autoclose.
// [RL3] Row-close samples line 10: high closes all banks, low only selected.
// [RL4] Mode-load takes the op-code presented on the address lines.
// [RL5] Commands are ignored while chip select is high, decoded when low.
// [RL6] Chip select is decoded as one bit of the command code.
// [RL7] Row, column and write strobes are latched each edge to form command.
// [RL8] Select and row strobe low, column high: write-enable picks open or close.
// [RL9] Open-row moves the selected bank into the active state.
// [RL10] Select low, row high, column low starts access; write low writes.
// [RL11] Write-enable chooses open/close in row and read/write in column commands.
// [RL12] Writes discard masked bytes; on reads the masks gate output drivers.
// [RL13] Data lines are driven and sampled on rising clock edges.
// [RL14] Read byte mask reaches the output drivers two clocks after sampling.
// [RL15] Close-all idles every bank at once, active or not.
// [RL16] Bank select 00, 01, 10, 11 address banks one to four.
module sdram_command_pin_decoder
(
   // Clock and reset
   input  wire logic                                  mclk_i,
   input  wire logic                                  nrst_i,
   // Command and address pins
   input  wire logic                                  chip_select_n_i,
   input  wire logic                                  row_strobe_n_i,
   input  wire logic                                  col_strobe_n_i,
   input  wire logic                                  write_enable_n_i,
   input  wire logic                                  bank_select_0_i,
   input  wire logic                                  bank_select_1_i,
   input  wire logic [sdram_pins_pkg::ADDR_W-1:0]     addr_i,
   input  wire logic                                  low_byte_mask_i,
   input  wire logic                                  high_byte_mask_i,
   // Data lines
   input  wire logic [sdram_pins_pkg::DATA_W-1:0]     data_lines_i,
   output logic      [sdram_pins_pkg::DATA_W-1:0]     data_lines_o,
   output logic      [sdram_pins_pkg::MASK_W-1:0]     data_lines_oe_o,
   // Decoded command
   output sdram_pins_pkg::cmd_t                       cmd_o,
   output logic      [sdram_pins_pkg::BANK_W-1:0]     bank_o,
   output logic      [sdram_pins_pkg::ADDR_W-1:0]     row_o,
   output logic      [sdram_pins_pkg::COL_W-1:0]      col_o,
   output logic                                       autoclose_o,
   output logic      [sdram_pins_pkg::ADDR_W-1:0]     mode_o,
   output logic      [sdram_pins_pkg::NBANK-1:0]      bank_active_o,
   // Read data from the array side
   input  wire logic                                  rd_valid_i,
   input  wire logic [sdram_pins_pkg::DATA_W-1:0]     rd_data_i,
   // Write data towards the array side
   output logic                                       wr_valid_o,
   input  wire logic                                  wr_ready_i,
   output sdram_pins_pkg::wr_word_t                   wr_word_o,
   output logic                                       buf_ready_o,
   output logic                                       wr_drop_o
);

   import sdram_pins_pkg::*;

   typedef struct packed {
      cmd_t              cmd;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] row;
      logic [COL_W-1:0]  col;
      logic              autoclose;
      logic [ADDR_W-1:0] mode;
      logic [NBANK-1:0]  active;
      logic [MASK_W-1:0] mask1;
      logic [DATA_W-1:0] dq;
      logic [MASK_W-1:0] oe;
      logic              push;
      wr_word_t          wword;
      logic              ready;
      logic              drop;
   } dec_state_t;

   dec_state_t        s_q;
   dec_state_t        s_d;
   pin_t              pins_raw;
   pin_t              p;
   cmd_t              dec;
   logic [NBANK-1:0]  bank_hot;
   logic              fifo_in_ready;

   assign pins_raw = '{cs_n:  chip_select_n_i,
                       ras_n: row_strobe_n_i,
                       cas_n: col_strobe_n_i,
                       we_n:  write_enable_n_i,
                       bank:  {bank_select_1_i, bank_select_0_i},
                       addr:  addr_i,
                       mask:  {high_byte_mask_i, low_byte_mask_i},
                       dq:    data_lines_i};

   // Pins come from another chip, so every one is synchronised
   pin_sync #(
      .W       ($bits(pin_t)),
      .RST_VAL (PIN_RST)
   ) u_sync (
      .mclk_i  (mclk_i),
      .nrst_i  (nrst_i),
      .async_i (pins_raw),
      .sync_o  (p)
   );

   // One-hot bank from the two select bits
   genvar gb;
   generate
      for (gb = 0; gb < NBANK; gb++)
      begin : g_bank
         assign bank_hot[gb] = (p.bank == BANK_W'(gb)); // RL16
      end
   endgenerate

   // Command decode; select is the top bit of the code
   always_comb
   begin
      dec = CMD_NONE;
      unique case ({p.cs_n, p.ras_n, p.cas_n, p.we_n}) // RL6 RL7
         4'b0011: dec = CMD_OPEN; // RL8 RL11
         4'b0010: dec = p.addr[ALL_BIT] ? CMD_CLOSE_ALL : CMD_CLOSE; // RL3 RL8
         4'b0101: dec = CMD_READ; // RL10 RL11
         4'b0100: dec = CMD_WRITE; // RL10 RL11
         4'b0000: dec = CMD_MODE;
         default: dec = CMD_NONE; // RL5
      endcase
   end

   always_comb
   begin
      s_d       = s_q;
      s_d.cmd   = dec;
      s_d.push  = 1'b0;
      s_d.drop  = 1'b0;
      s_d.ready = fifo_in_ready;
      unique case (dec)
         CMD_OPEN:
         begin
            s_d.bank   = p.bank;
            s_d.row    = p.addr; // RL1
            s_d.active = s_q.active | bank_hot; // RL9
         end
         CMD_CLOSE:
         begin
            s_d.bank   = p.bank;
            s_d.active = s_q.active & ~bank_hot; // RL3
         end
         CMD_CLOSE_ALL:
            s_d.active = '0; // RL15
         CMD_READ, CMD_WRITE:
         begin
            s_d.bank      = p.bank;
            s_d.col       = p.addr[COL_W-1:0]; // RL2
            s_d.autoclose = p.addr[ALL_BIT]; // RL2
            // No burst model: autoclose idles the bank right away
            if (p.addr[ALL_BIT])
               s_d.active = s_q.active & ~bank_hot;
         end
         CMD_MODE:
            s_d.mode = p.addr; // RL4
         default:
            s_d.active = s_q.active;
      endcase
      // Write data taken on the command edge; masked bytes dropped
      if (dec == CMD_WRITE)
      begin
         s_d.push                = 1'b1; // RL13
         s_d.wword.byte_en       = ~p.mask; // RL12
         s_d.wword.data[7:0]     = p.mask[0] ? 8'h00 : p.dq[7:0]; // RL12
         s_d.wword.data[15:8]    = p.mask[1] ? 8'h00 : p.dq[15:8]; // RL12
      end
      // Full buffer cannot stall the pins, so the word is lost and flagged
      if (s_q.push && !fifo_in_ready)
         s_d.drop = 1'b1;
      // Mask pipeline: one stage here, the output flop is the second
      s_d.mask1 = p.mask;
      s_d.dq    = rd_data_i; // RL13
      s_d.oe    = {MASK_W{rd_valid_i}} & ~s_q.mask1; // RL12 RL14
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         s_q        <= '0;
         s_q.cmd    <= CMD_NONE;
         s_q.mode   <= MODE_RST;
         s_q.active <= ACTIVE_RST;
      end
      else
         s_q <= s_d;
   end

   word_fifo #(
      .W     ($bits(wr_word_t)),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .mclk_i      (mclk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (s_q.push),
      .in_ready_o  (fifo_in_ready),
      .in_data_i   (s_q.wword),
      .out_valid_o (wr_valid_o),
      .out_ready_i (wr_ready_i),
      .out_data_o  (wr_word_o)
   );

   assign cmd_o           = s_q.cmd;
   assign bank_o          = s_q.bank;
   assign row_o           = s_q.row;
   assign col_o           = s_q.col;
   assign autoclose_o     = s_q.autoclose;
   assign mode_o          = s_q.mode;
   assign bank_active_o   = s_q.active;
   assign data_lines_o    = s_q.dq;
   assign data_lines_oe_o = s_q.oe;
   assign buf_ready_o     = s_q.ready;
   assign wr_drop_o       = s_q.drop;

   a_deselect_ignored: assert property ( // RL5
      @(posedge mclk_i) disable iff (!nrst_i)
      $past(p.cs_n) |-> cmd_o == CMD_NONE)
      else $error("command decoded while deselected");

   a_open_decode: assert property ( // RL1
      @(posedge mclk_i) disable iff (!nrst_i)
      ##1 ($past({p.cs_n, p.ras_n, p.cas_n, p.we_n}) == 4'b0011)
      |-> cmd_o == CMD_OPEN && row_o == $past(p.addr) && bank_o == $past(p.bank))
      else $error("open row not captured");

   a_open_activates: assert property ( // RL9
      @(posedge mclk_i) disable iff (!nrst_i)
      cmd_o == CMD_OPEN |-> bank_active_o[bank_o])
      else $error("opened bank not active");

   a_open_one_bank: assert property ( // RL16
      @(posedge mclk_i) disable iff (!nrst_i)
      cmd_o == CMD_OPEN |-> bank_active_o == ($past(bank_active_o) | (4'h1 << bank_o)))
      else $error("open touched another bank");

   a_close_decode: assert property ( // RL3
      @(posedge mclk_i) disable iff (!nrst_i)
      ##1 ($past({p.cs_n, p.ras_n, p.cas_n, p.we_n}) == 4'b0010)
      |-> cmd_o == ($past(p.addr[ALL_BIT]) ? CMD_CLOSE_ALL : CMD_CLOSE))
      else $error("close kind not taken from line ten");

   a_close_all_idle: assert property ( // RL15
      @(posedge mclk_i) disable iff (!nrst_i)
      cmd_o == CMD_CLOSE_ALL |-> bank_active_o == 4'h0)
      else $error("close all left a bank active");

   a_close_one_bank: assert property ( // RL3
      @(posedge mclk_i) disable iff (!nrst_i)
      cmd_o == CMD_CLOSE |-> !bank_active_o[bank_o]
         && ((bank_active_o | (4'h1 << bank_o)) == ($past(bank_active_o) | (4'h1 << bank_o))))
      else $error("single close touched other banks");

   a_column_kind: assert property ( // RL10 RL11
      @(posedge mclk_i) disable iff (!nrst_i)
      ##1 ($past({p.cs_n, p.ras_n, p.cas_n}) == 3'b010)
      |-> cmd_o == ($past(p.we_n) ? CMD_READ : CMD_WRITE))
      else $error("column access kind wrong");

   a_column_take: assert property ( // RL2
      @(posedge mclk_i) disable iff (!nrst_i)
      ##1 ($past({p.cs_n, p.ras_n, p.cas_n}) == 3'b010)
      |-> col_o == $past(p.addr[COL_W-1:0]) && autoclose_o == $past(p.addr[ALL_BIT]))
      else $error("column or autoclose wrong");

   a_autoclose_idle: assert property ( // RL2
      @(posedge mclk_i) disable iff (!nrst_i)
      (cmd_o == CMD_READ || cmd_o == CMD_WRITE) && autoclose_o |-> !bank_active_o[bank_o])
      else $error("autoclose left bank active");

   a_mode_load: assert property ( // RL4
      @(posedge mclk_i) disable iff (!nrst_i)
      cmd_o == CMD_MODE |-> mode_o == $past(p.addr))
      else $error("mode op-code not loaded");

   a_refused_hold: assert property ( // RL5
      @(posedge mclk_i) disable iff (!nrst_i)
      cmd_o == CMD_NONE |-> $stable(bank_active_o) && $stable(mode_o))
      else $error("refused command changed state");

   a_mask_latency: assert property ( // RL14
      @(posedge mclk_i) disable iff (!nrst_i)
      ##2 (data_lines_oe_o != 2'h0) |-> ($past(p.mask, 2) & data_lines_oe_o) == 2'h0)
      else $error("read mask latency not two clocks");

   a_oe_idle: assert property ( // RL12
      @(posedge mclk_i) disable iff (!nrst_i)
      ##1 (!$past(rd_valid_i)) |-> data_lines_oe_o == 2'h0)
      else $error("drivers on without read data");

   a_read_drive: assert property ( // RL13
      @(posedge mclk_i) disable iff (!nrst_i)
      ##1 1'b1 |-> data_lines_o == $past(rd_data_i))
      else $error("read data not one edge late");

   a_write_discard: assert property ( // RL12
      @(posedge mclk_i) disable iff (!nrst_i)
      s_q.push |-> s_q.wword.byte_en == ~$past(p.mask))
      else $error("masked write byte kept");

   a_masked_zero: assert property ( // RL12
      @(posedge mclk_i) disable iff (!nrst_i)
      s_q.push |-> (s_q.wword.byte_en[0] || s_q.wword.data[7:0] == 8'h00)
         && (s_q.wword.byte_en[1] || s_q.wword.data[15:8] == 8'h00))
      else $error("masked byte data not cleared");

endmodule : sdram_command_pin_decoder
`default_nettype wire

// ---- design/sdram_pins_pkg.sv ----
`default_nettype none
package sdram_pins_pkg;

   localparam int ADDR_W    = 13;
   localparam int COL_W     = 9;
   localparam int DATA_W    = 16;
   localparam int MASK_W    = 2;
   localparam int BANK_W    = 2;
   localparam int NBANK     = 4;
   localparam int ALL_BIT   = 10;
   localparam int FIFO_DEPTH = 16;
   localparam int SYNC_STAGES = 2;

   localparam logic [ADDR_W-1:0] MODE_RST   = 13'h0000;
   localparam logic [NBANK-1:0]  ACTIVE_RST = 4'h0;

   typedef enum logic [2:0] {
      CMD_NONE,
      CMD_OPEN,
      CMD_CLOSE,
      CMD_CLOSE_ALL,
      CMD_READ,
      CMD_WRITE,
      CMD_MODE
   } cmd_t;

   typedef struct packed {
      logic              cs_n;
      logic              ras_n;
      logic              cas_n;
      logic              we_n;
      logic [BANK_W-1:0] bank;
      logic [ADDR_W-1:0] addr;
      logic [MASK_W-1:0] mask;
      logic [DATA_W-1:0] dq;
   } pin_t;

   // Idle pin levels, so a synchroniser leaving reset shows no command
   localparam pin_t PIN_RST = '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                                bank: '0, addr: '0, mask: '0, dq: '0};

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic [MASK_W-1:0] byte_en;
   } wr_word_t;

endpackage : sdram_pins_pkg
`default_nettype wire

// ---- design/word_fifo.sv ----
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
   parameter int W     = 18,
   parameter int DEPTH = 16
) (
   // Clock and reset
   input  wire logic         mclk_i,
   input  wire logic         nrst_i,
   // Fill side
   input  wire logic         in_valid_i,
   output logic              in_ready_o,
   input  wire logic [W-1:0] in_data_i,
   // Drain side
   output logic              out_valid_o,
   input  wire logic         out_ready_i,
   output logic      [W-1:0] out_data_o
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0]   count;
   } fifo_state_t;

   fifo_state_t      s_q;
   fifo_state_t      s_d;
   logic [W-1:0]     mem_q [DEPTH];
   logic             push;
   logic             pop;

   assign in_ready_o  = (s_q.count != (AW+1)'(DEPTH));
   assign out_valid_o = (s_q.count != '0);
   assign out_data_o  = mem_q[s_q.rd];
   assign push        = in_valid_i && in_ready_o;
   assign pop         = out_valid_o && out_ready_i;

   always_comb
   begin
      s_d = s_q;
      if (push)
         s_d.wr = s_q.wr + 1'b1;
      if (pop)
         s_d.rd = s_q.rd + 1'b1;
      s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge mclk_i or negedge nrst_i)
   begin
      if (!nrst_i)
         s_q <= '0;
      else
         s_q <= s_d;
   end

   // Storage needs no reset; count guards every read
   always_ff @(posedge mclk_i)
   begin
      if (push)
         mem_q[s_q.wr] <= in_data_i;
   end

endmodule : word_fifo
`default_nettype wire
